// ===== rtl/dcp_pwm.sv
// dcp_pwm.sv: two channel 8-bit pwm with a classic wishbone slave
// assumes: single clock, async active-low reset, byte-addressed wishbone
`timescale 1ns/1ns
`default_nettype none
`include "dcp_defines.svh"
module dcp_pwm
  import dcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] port_out_i,
  output logic channel_a_pin_o,
  output logic channel_a_pin_oe_n_o,
  output logic channel_b_pin_o,
  output logic channel_b_pin_oe_n_o
);
  dcp_state_t s_r;
  dcp_state_t s_nxt;
  logic req;
  logic wr;
  logic unit_end;
  logic base_end;
  logic cyc_end;
  logic en_a;
  logic en_b;

  assign req = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  // unit ends after four ticks in quad mode, else every tick
  assign unit_end = !s_r.act_quad || (s_r.tick_cnt == `DCP_UNIT_QUAD);
  assign base_end = unit_end && (s_r.unit_cnt == s_r.act_base);
  assign cyc_end = base_end && (s_r.step_cnt == 8'hff);
  assign en_a = s_r.ctrl[`DCP_BIT_CHANNEL_A_ENABLE];
  assign en_b = s_r.ctrl[`DCP_BIT_CHANNEL_B_ENABLE];

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = req;
    if (req && !wb_we_i) begin
      s_nxt.dat = 32'h0000_0000;
      unique case (wb_adr_i)
        `DCP_OFF_CHANNEL_A_DUTY: s_nxt.dat[7:0] = s_r.duty_a;
        `DCP_OFF_CHANNEL_B_DUTY: s_nxt.dat[7:0] = s_r.duty_b;
        `DCP_OFF_BASE_PERIOD_LENGTH: s_nxt.dat[7:0] = s_r.base;
        `DCP_OFF_PORT_C_CONTROL: s_nxt.dat[7:0] = s_r.ctrl;
        `DCP_OFF_PIN_DIRECTION: s_nxt.dat[7:0] = s_r.dir;
        default: s_nxt.dat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i)
        `DCP_OFF_CHANNEL_A_DUTY: s_nxt.duty_a = wb_dat_i[7:0];
        `DCP_OFF_CHANNEL_B_DUTY: s_nxt.duty_b = wb_dat_i[7:0];
        // writable over the bus so software can set it at all
        `DCP_OFF_BASE_PERIOD_LENGTH: s_nxt.base = wb_dat_i[7:0];
        `DCP_OFF_PORT_C_CONTROL: s_nxt.ctrl = wb_dat_i[7:0];
        `DCP_OFF_PIN_DIRECTION: s_nxt.dir = wb_dat_i[7:0];
        default: ;
      endcase
    end
    // timebase
    s_nxt.tick_cnt = unit_end ? 2'h0 : s_r.tick_cnt + 2'h1;
    if (unit_end) begin
      s_nxt.unit_cnt = base_end ? 8'h00 : s_r.unit_cnt + 8'h01;
    end
    if (base_end) begin
      s_nxt.step_cnt = s_r.step_cnt + 8'h01; // wraps at 256
    end
    // shadow load only at cycle end, so no runt pulse
    if (cyc_end) begin
      s_nxt.act_duty_a = s_r.duty_a;
      s_nxt.act_duty_b = s_r.duty_b;
      s_nxt.act_base = s_r.base;
      s_nxt.act_quad = s_r.ctrl[`DCP_BIT_PRESCALE];
    end
    // high during steps 0..duty, so duty+1 base periods
    if (cyc_end) begin
      s_nxt.pwm_a = 1'b1;
      s_nxt.pwm_b = 1'b1;
    end else if (base_end) begin
      if (s_r.step_cnt == s_r.act_duty_a) begin
        s_nxt.pwm_a = 1'b0;
      end
      if (s_r.step_cnt == s_r.act_duty_b) begin
        s_nxt.pwm_b = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
      s_r.duty_a <= `DCP_RST_DUTY;
      s_r.duty_b <= `DCP_RST_DUTY;
      s_r.base <= `DCP_RST_BASE;
      s_r.act_base <= `DCP_RST_BASE;
      s_r.ctrl <= `DCP_RST_CTRL;
      s_r.dir <= `DCP_RST_DIR;
      s_r.pwm_a <= 1'b1;
      s_r.pwm_b <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  // enable overrides direction bit
  assign channel_a_pin_o = en_a ? s_r.pwm_a : port_out_i[0];
  assign channel_b_pin_o = en_b ? s_r.pwm_b : port_out_i[1];
  assign channel_a_pin_oe_n_o = !en_a && s_r.dir[`DCP_BIT_PIN_A_DIRECTION];
  assign channel_b_pin_oe_n_o = !en_b && s_r.dir[`DCP_BIT_PIN_B_DIRECTION];

  property p_one_tick_unit;
    @(posedge clk_i) disable iff (!arst_n_i)
    !s_r.act_quad |-> unit_end;
  endproperty
  a_one_tick_unit: assert property (p_one_tick_unit)
    else $error("unit not one tick");

  sequence s_quad_gap;
    !unit_end [*3] ##1 unit_end;
  endsequence

  property p_quad_unit;
    @(posedge clk_i) disable iff (!arst_n_i)
    (s_r.act_quad && unit_end && !cyc_end) |=> s_quad_gap;
  endproperty
  a_quad_unit: assert property (p_quad_unit)
    else $error("quad unit not four ticks");

  property p_cycle_wrap;
    @(posedge clk_i) disable iff (!arst_n_i)
    cyc_end |=> (s_r.step_cnt == 8'h00) && (s_r.unit_cnt == 8'h00);
  endproperty
  a_cycle_wrap: assert property (p_cycle_wrap)
    else $error("cycle not 256 steps");

  // each base period advances the step count by exactly one
  property p_step_count;
    @(posedge clk_i) disable iff (!arst_n_i)
    (base_end && !cyc_end) |=> s_r.step_cnt == $past(s_r.step_cnt) + 8'h01;
  endproperty
  a_step_count: assert property (p_step_count)
    else $error("step count skipped");

  property p_high_start;
    @(posedge clk_i) disable iff (!arst_n_i)
    cyc_end |=> s_r.pwm_a && s_r.pwm_b;
  endproperty
  a_high_start: assert property (p_high_start)
    else $error("pwm not high at cycle start");

  property p_fall_a;
    @(posedge clk_i) disable iff (!arst_n_i)
    (base_end && !cyc_end && s_r.step_cnt == s_r.act_duty_a) |=> !s_r.pwm_a;
  endproperty
  a_fall_a: assert property (p_fall_a)
    else $error("channel a did not fall");

  property p_fall_b;
    @(posedge clk_i) disable iff (!arst_n_i)
    (base_end && !cyc_end && s_r.step_cnt == s_r.act_duty_b) |=> !s_r.pwm_b;
  endproperty
  a_fall_b: assert property (p_fall_b)
    else $error("channel b did not fall");

  property p_stay_b;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!base_end) |=> $stable(s_r.pwm_b);
  endproperty
  a_stay_b: assert property (p_stay_b)
    else $error("channel b moved mid step");

  property p_override;
    @(posedge clk_i) disable iff (!arst_n_i)
    en_a |-> !channel_a_pin_oe_n_o && channel_a_pin_o == s_r.pwm_a;
  endproperty
  a_override: assert property (p_override)
    else $error("enabled channel a not driving");

  property p_override_b;
    @(posedge clk_i) disable iff (!arst_n_i)
    en_b |-> !channel_b_pin_oe_n_o && channel_b_pin_o == s_r.pwm_b;
  endproperty
  a_override_b: assert property (p_override_b)
    else $error("enabled channel b not driving");

  // disabled pins fall back to their direction bit
  property p_dir_a;
    @(posedge clk_i) disable iff (!arst_n_i)
    !en_a |-> channel_a_pin_oe_n_o == s_r.dir[`DCP_BIT_PIN_A_DIRECTION];
  endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("pin a direction ignored");

  property p_dir_b;
    @(posedge clk_i) disable iff (!arst_n_i)
    !en_b |-> channel_b_pin_oe_n_o == s_r.dir[`DCP_BIT_PIN_B_DIRECTION];
  endproperty
  a_dir_b: assert property (p_dir_b)
    else $error("pin b direction ignored");

  property p_shadow;
    @(posedge clk_i) disable iff (!arst_n_i)
    !cyc_end |=> $stable(s_r.act_duty_a) && $stable(s_r.act_base);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("active value changed mid cycle");

  property p_ack_once;
    @(posedge clk_i) disable iff (!arst_n_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held two cycles");

  property p_ack_next;
    @(posedge clk_i) disable iff (!arst_n_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("request not acked next cycle");
endmodule : dcp_pwm
`default_nettype wire

// ===== rtl/dcp_defines.svh
// dcp_defines.svh: offsets, field positions and reset values of the pwm
// assumes: included by the pwm module only; the package does not include it
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH
`define DCP_OFF_CHANNEL_A_DUTY 8'h0c
`define DCP_OFF_CHANNEL_B_DUTY 8'h0d
`define DCP_OFF_BASE_PERIOD_LENGTH 8'h18
`define DCP_OFF_PORT_C_CONTROL 8'h20
`define DCP_OFF_PIN_DIRECTION 8'h21
`define DCP_BIT_PRESCALE 0
`define DCP_BIT_CHANNEL_A_ENABLE 6
`define DCP_BIT_CHANNEL_B_ENABLE 7
`define DCP_BIT_PIN_A_DIRECTION 2
`define DCP_BIT_PIN_B_DIRECTION 3
`define DCP_RST_DUTY 8'h00
`define DCP_RST_BASE 8'h01
`define DCP_RST_CTRL 8'h00
`define DCP_RST_DIR 8'hff
`define DCP_UNIT_QUAD 2'h3
`endif

// ===== rtl/dcp_pkg.sv
// dcp_pkg.sv: types shared by the dual channel pwm
// assumes: standalone; it does not include dcp_defines.svh
package dcp_pkg;
  typedef struct packed {
    logic [7:0] duty_a;
    logic [7:0] duty_b;
    logic [7:0] base;
    logic [7:0] ctrl;
    logic [7:0] dir;
    logic [7:0] act_duty_a;
    logic [7:0] act_duty_b;
    logic [7:0] act_base;
    logic act_quad;
    logic [1:0] tick_cnt;
    logic [7:0] unit_cnt;
    logic [7:0] step_cnt;
    logic pwm_a;
    logic pwm_b;
    logic ack;
    logic [31:0] dat;
  } dcp_state_t;
endpackage : dcp_pkg

// ===== test/tb.sv
// tb.sv: self-checking bench for the dual channel pwm
// assumes: dcp_pwm compiled first; one 20 MHz clock, no partner model
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [1:0] port_out = 2'h0;
  logic ack, pa, pa_oe_n, pb, pb_oe_n;
  int miscompares = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  dcp_pwm i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .port_out_i(port_out), .channel_a_pin_o(pa),
    .channel_a_pin_oe_n_o(pa_oe_n), .channel_b_pin_o(pb),
    .channel_b_pin_oe_n_o(pb_oe_n));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic test_done;
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // watchdog: count rising edges and fail the run at 40000 cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      miscompares++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    chk("ack wait", 2, n);
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h00_0000, exp}, rdat);
  endtask : rchk
  task automatic t_reset;
    chk("oe_n", 2'b11, {pa_oe_n, pb_oe_n});
    rchk(8'h0c, 8'h00);
    rchk(8'h0d, 8'h00);
    rchk(8'h18, 8'h01);
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'hff);
    rchk(8'h30, 8'h00);
  endtask : t_reset
  task automatic t_regs;
    bus(1'b1, 8'h0c, 8'ha5);
    bus(1'b1, 8'h0d, 8'h5a);
    bus(1'b1, 8'h30, 8'hff);
    rchk(8'h0c, 8'ha5);
    rchk(8'h0d, 8'h5a);
    rchk(8'h30, 8'h00);
  endtask : t_regs
  // high count over one whole cycle is phase independent
  task automatic t_pwm(input logic q, input logic [7:0] b, da, db);
    int len, ca, cb, per;
    per = (int'(b) + 1) * (q ? 4 : 1);
    len = 256 * per;
    ca = 0;
    cb = 0;
    bus(1'b1, 8'h18, b);
    bus(1'b1, 8'h0c, da);
    bus(1'b1, 8'h0d, db);
    bus(1'b1, 8'h20, {7'h60, q});
    repeat (2 * len) @(posedge clk_i);
    chk("oe_n", 2'b00, {pa_oe_n, pb_oe_n});
    repeat (len) begin
      @(posedge clk_i);
      ca += (pa === 1'b1);
      cb += (pb === 1'b1);
    end
    chk("high a", (int'(da) + 1) * per, ca);
    chk("high b", (int'(db) + 1) * per, cb);
  endtask : t_pwm
  task automatic t_port;
    port_out <= 2'b01;
    bus(1'b1, 8'h20, 8'h00);
    bus(1'b1, 8'h21, 8'hf3);
    @(posedge clk_i);
    chk("pins", 4'b1000, {pa, pb, pa_oe_n, pb_oe_n});
    bus(1'b1, 8'h21, 8'hff);
    @(posedge clk_i);
    chk("oe_n", 2'b11, {pa_oe_n, pb_oe_n});
  endtask : t_port
  // second reset in mid-run must clear enables again
  task automatic t_rerst;
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset;
  endtask : t_rerst
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_regs;
    t_pwm(1'b0, 8'h01, 8'h02, 8'h05);
    t_pwm(1'b0, 8'h03, 8'hff, 8'h00);
    t_pwm(1'b1, 8'h01, 8'h00, 8'h7f);
    t_rerst;
    t_port;
    test_done;
  end
endmodule : tb
`default_nettype wire
